// ==== core/acstc_consts.vh ====
/*
  constants for the converter scan and charge timer control block:
  register byte offsets, field positions, reset values.
  assumes 32-bit apb words, 16-bit control registers in the low half; status reads edge flags in bits 17:16.
*/
`ifndef ACSTC_CONSTS_VH
`define ACSTC_CONSTS_VH

`define ACSTC_OFF_CHARGE_CTRL1    12'h000
`define ACSTC_OFF_CONV_CTRL2      12'h004
`define ACSTC_OFF_SCAN_SELECT     12'h008
`define ACSTC_OFF_CHARGE_STATUS   12'h00C

`define ACSTC_RST_CHARGE_CTRL1    16'h0000
`define ACSTC_RST_CONV_CTRL2      16'h0000
`define ACSTC_RST_SCAN_SELECT     16'h0000

`define ACSTC_CC1_WMASK           16'hBF00
`define ACSTC_CC2_WMASK           16'hE77F

`define ACSTC_BIT_UNIT_ENABLE     15
`define ACSTC_BIT_IDLE_STOP       13
`define ACSTC_BIT_TIME_GEN        12
`define ACSTC_BIT_EDGE_SOURCE     11
`define ACSTC_BIT_EDGE_ORDER      10
`define ACSTC_BIT_DISCHARGE       9
`define ACSTC_BIT_CONV_TRIGGER    8

`define ACSTC_REFCFG_HI           15
`define ACSTC_REFCFG_LO           13
`define ACSTC_BIT_SCAN_ENABLE     10
`define ACSTC_BIT_BUF_HALF        7
`define ACSTC_SAMPLES_PER_EVENT_HI             6
`define ACSTC_SAMPLES_PER_EVENT_LO             2
`define ACSTC_BIT_BUF_MODE        1

`define ACSTC_REF_BOTH_SUPPLY     3'h0
`define ACSTC_REF_EXTP_GND        3'h1
`define ACSTC_REF_SUPPLY_EXTN     3'h2
`define ACSTC_REF_BOTH_EXT        3'h3

`endif

// ==== core/acstc_ctrl.v ====
/*
  converter scan and charge timer control: apb register file, charge timer
  edge delay generation, discharge and converter trigger, reference select,
  scan sequencing with buffer half tracking.
  assumes an apb master on pclk, analog front end taking the decoded controls.
*/
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`default_nettype none
`include "acstc_consts.vh"

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - time generation bit enables edge delay generation; clear disables it
// - edge source bit picks hardware edges; zero means software edge bits only
// - edge order bit blocks second edge until first edge has occurred
// - discharge bit grounds current source output; clear leaves it floating
// - trigger bit lets charge timer start converter conversions
// - converter never auto-discharges sample-hold between conversions
// - three-bit reference field selects high and low references; 1xx means supplies
// - read-only buffer half bit shows which half is filling
// - scan includes inputs whose mask bit is one, skips others
// - selected input absent on device converts low reference instead
module acstc_ctrl #(
  parameter NUM_INPUTS  = 9,
  parameter BUF_WORDS   = 16,
  parameter DELAY_WIDTH = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [1:0]  hw_edge,
  input  wire        conv_done,
  output reg         current_source_ground,
  output reg         conv_start,
  output reg         sample_hold_discharge,
  output reg  [1:0]  high_reference,
  output reg  [1:0]  low_reference,
  output reg  [3:0]  conv_input_sel,
  output reg         conv_use_low_ref,
  output reg  [DELAY_WIDTH-1:0] edge_delay
);

  //////////////////////////////////////////////////////////////////////////
  // register file
  reg  [15:0] charge_timer_control_1;
  reg  [15:0] converter_control_2;
  reg  [15:0] converter_scan_select_low;
  reg         buffer_half_status;
  wire [1:0]  edge_status_bits;
  wire [1:0]  edge_accept;

  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & ~penable & ~pwrite;
  wire addr_hit = (paddr == `ACSTC_OFF_CHARGE_CTRL1) | (paddr == `ACSTC_OFF_CONV_CTRL2) |
                  (paddr == `ACSTC_OFF_SCAN_SELECT) | (paddr == `ACSTC_OFF_CHARGE_STATUS);

  // zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  wire wr_cc1    = wr_en & (paddr == `ACSTC_OFF_CHARGE_CTRL1);
  wire wr_cc2    = wr_en & (paddr == `ACSTC_OFF_CONV_CTRL2);
  wire wr_scan   = wr_en & (paddr == `ACSTC_OFF_SCAN_SELECT);
  wire wr_status = wr_en & (paddr == `ACSTC_OFF_CHARGE_STATUS);

  wire unit_on      = charge_timer_control_1[`ACSTC_BIT_UNIT_ENABLE];
  wire time_gen     = charge_timer_control_1[`ACSTC_BIT_TIME_GEN];
  wire discharge    = charge_timer_control_1[`ACSTC_BIT_DISCHARGE];
  wire trig_enable  = charge_timer_control_1[`ACSTC_BIT_CONV_TRIGGER];
  wire scan_enable  = converter_control_2[`ACSTC_BIT_SCAN_ENABLE];
  wire [2:0] reference_config = converter_control_2[`ACSTC_REFCFG_HI:`ACSTC_REFCFG_LO];

  // status word: write 1 to bit n sets edge n (software edges), bit n+2 clears it
  wire [1:0] sw_edge_set = (wr_status & ~charge_timer_control_1[`ACSTC_BIT_EDGE_SOURCE]) ?
                           pwdata[1:0] : 2'h0;
  wire [1:0] sw_edge_clr = wr_status ? pwdata[3:2] : 2'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_timer_control_1    <= `ACSTC_RST_CHARGE_CTRL1;
      converter_control_2       <= `ACSTC_RST_CONV_CTRL2;
      converter_scan_select_low <= `ACSTC_RST_SCAN_SELECT;
    end else if (ce) begin
      if (wr_cc1) begin
        charge_timer_control_1 <= pwdata[15:0] & `ACSTC_CC1_WMASK;
      end
      if (wr_cc2) begin
        // buffer half bit is hardware owned and never written
        converter_control_2 <= pwdata[15:0] & `ACSTC_CC2_WMASK;
      end
      if (wr_scan) begin
        converter_scan_select_low <= pwdata[15:0];
      end
    end
  end

  // read data registered in setup so it is stable through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce && rd_en) begin
      case (paddr)
        `ACSTC_OFF_CHARGE_CTRL1:  prdata <= {16'h0000, charge_timer_control_1};
        `ACSTC_OFF_CONV_CTRL2:    prdata <= {16'h0000, converter_control_2[15:8],
                                             buffer_half_status, converter_control_2[6:0]};
        `ACSTC_OFF_SCAN_SELECT:   prdata <= {16'h0000, converter_scan_select_low};
        `ACSTC_OFF_CHARGE_STATUS: prdata <= {14'h0000, edge_status_bits, edge_delay};
        default:                  prdata <= 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // charge timer edges
  acstc_edge_unit u_edge (
    .pclk               (pclk),
    .presetn            (presetn),
    .ce                 (ce),
    .unit_on            (unit_on),
    .edge_source_select (charge_timer_control_1[`ACSTC_BIT_EDGE_SOURCE]),
    .edge_order_enable  (charge_timer_control_1[`ACSTC_BIT_EDGE_ORDER]),
    .hw_edge            (hw_edge),
    .sw_edge_set        (sw_edge_set),
    .sw_edge_clr        (sw_edge_clr),
    .edge_status_bits   (edge_status_bits),
    .edge_accept        (edge_accept)
  );

  // edge delay generation: counts cycles from first edge until second edge
  reg delay_running;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_running <= 1'b0;
      edge_delay    <= {DELAY_WIDTH{1'b0}};
    end else if (ce) begin
      if (!unit_on || !time_gen) begin
        delay_running <= 1'b0;
      end else if (edge_accept[0] && !delay_running) begin
        delay_running <= 1'b1;
        edge_delay    <= {DELAY_WIDTH{1'b0}};
      end else if (delay_running) begin
        if (edge_accept[1]) begin
          delay_running <= 1'b0;
        end
        // saturate rather than wrap so a long gap never reads short
        if (edge_delay != {DELAY_WIDTH{1'b1}}) begin
          edge_delay <= edge_delay + {{(DELAY_WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // discharge outputs: current source ground and sample-hold sink
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_source_ground <= 1'b0;
      sample_hold_discharge <= 1'b0;
    end else if (ce) begin
      current_source_ground <= unit_on & discharge;
      // sample-hold sink only follows the software bit, never the conversion cycle
      sample_hold_discharge <= unit_on & discharge;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reference selection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_reference <= 2'h0;
      low_reference  <= 2'h0;
    end else if (ce) begin
      // high: 0 supply, 1 external; low: 0 ground, 1 external
      case (reference_config)
        `ACSTC_REF_EXTP_GND: begin
          high_reference <= 2'h1;
          low_reference  <= 2'h0;
        end
        `ACSTC_REF_SUPPLY_EXTN: begin
          high_reference <= 2'h0;
          low_reference  <= 2'h1;
        end
        `ACSTC_REF_BOTH_EXT: begin
          high_reference <= 2'h1;
          low_reference  <= 2'h1;
        end
        // 000 and every 1xx pattern fall back to the analog supplies
        default: begin
          high_reference <= 2'h0;
          low_reference  <= 2'h0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // scan sequencing and conversion start
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_CONV = 2'h2;
  reg  [1:0] state;
  reg  [4:0] buf_count;
  wire       trig_fire = unit_on & trig_enable & edge_accept[1];
  // discharge keeps the converter sampling, so no conversion starts meanwhile
  wire       start_ok  = trig_fire & ~(unit_on & discharge);

  // next selected input strictly after current, wrapping
  reg  [3:0] next_input;
  reg        next_found;
  integer    k;
  always @* begin
    next_input = conv_input_sel;
    next_found = 1'b0;
    for (k = 1; k <= 16; k = k + 1) begin
      if (!next_found && converter_scan_select_low[(conv_input_sel + k) % 16]) begin
        next_input = conv_input_sel + k[3:0];
        next_found = 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state              <= ST_IDLE;
      conv_start         <= 1'b0;
      conv_input_sel     <= 4'h0;
      conv_use_low_ref   <= 1'b0;
      buf_count          <= 5'h00;
      buffer_half_status <= 1'b0;
    end else if (ce) begin
      conv_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_ok) begin
            if (scan_enable && next_found) begin
              conv_input_sel   <= next_input;
              // absent inputs sample the low reference
              conv_use_low_ref <= ({28'h0000000, next_input} >= NUM_INPUTS);
            end else if (!scan_enable) begin
              conv_input_sel   <= 4'h0;
              conv_use_low_ref <= 1'b0;
            end
            conv_start <= 1'b1;
            state      <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            if ({27'h0000000, buf_count} == BUF_WORDS - 1) begin
              buf_count          <= 5'h00;
              buffer_half_status <= ~buffer_half_status;
            end else begin
              buf_count <= buf_count + 5'h01;
            end
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // acstc_ctrl

`default_nettype wire

// ==== core/acstc_edge_unit.v ====
/*
  charge timer edge unit: qualifies edge events from hardware or software,
  applies optional first-before-second ordering, holds edge status flags.
  assumes inputs synchronous to pclk.
*/
`default_nettype none

module acstc_edge_unit (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        unit_on,
  input  wire        edge_source_select,
  input  wire        edge_order_enable,
  input  wire [1:0]  hw_edge,
  input  wire [1:0]  sw_edge_set,
  input  wire [1:0]  sw_edge_clr,
  output reg  [1:0]  edge_status_bits,
  output wire [1:0]  edge_accept
);

  wire [1:0] raw_edge;

  // hardware sources only count when selected; software sets otherwise
  assign raw_edge = edge_source_select ? hw_edge : sw_edge_set;
  assign edge_accept[0] = unit_on & raw_edge[0];
  // with edge ordering enabled, second edge needs the first one already seen (or arriving now)
  assign edge_accept[1] = unit_on & raw_edge[1] &
                          (~edge_order_enable | edge_status_bits[0] | edge_accept[0]);

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_flag
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          edge_status_bits[g] <= 1'b0;
        end else if (ce) begin
          // set wins over a same-cycle clear
          if (edge_accept[g]) begin
            edge_status_bits[g] <= 1'b1;
          end else if (sw_edge_clr[g] || !unit_on) begin
            edge_status_bits[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule // acstc_edge_unit

`default_nettype wire

// ==== verification/acstc_conv_model.sv ====
/* converter model: answers each start with one done pulse.
   assumes start is a one-cycle pulse on pclk. */
`default_nettype none
module acstc_conv_model #(parameter LAT = 4) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic conv_start,
  output var  logic conv_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  // held charge is never dropped between conversions; only the sink clears it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h0;
      conv_done <= 1'h0;
    end else begin
      conv_done <= (cnt == 8'h1);
      if (conv_start) cnt <= 8'(LAT);
      else if (cnt != 8'h0) cnt <= cnt - 8'h1;
    end
  end
endmodule // acstc_conv_model
`default_nettype wire

// ==== verification/acstc_monitor.sv ====
/* port checker for acstc_ctrl, bound into it.
   assumes apb writes on pclk and design outputs only. */
`default_nettype none
`include "acstc_consts.vh"
module acstc_monitor #(parameter NUM_INPUTS = 9) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        conv_start,
  input wire logic        current_source_ground,
  input wire logic        sample_hold_discharge,
  input wire logic [1:0]  high_reference,
  input wire logic [1:0]  low_reference,
  input wire logic [3:0]  conv_input_sel,
  input wire logic        conv_use_low_ref
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic        wr = psel & penable & pwrite & ce;
  wire logic        wr4 = wr && paddr == `ACSTC_OFF_CONV_CTRL2;
  wire logic        wr1 = wr && paddr == `ACSTC_OFF_CHARGE_CTRL1;
  logic      [1:0]  dis_q;
  logic      [2:0]  cfg_q;
  logic      [15:0] mask_q;
  // shadows of the written fields, so outputs are judged against software intent
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 3'h0;
      mask_q <= 16'h0;
      dis_q <= 2'h0;
    end else begin
      if (wr1) dis_q <= {pwdata[`ACSTC_BIT_UNIT_ENABLE], pwdata[`ACSTC_BIT_DISCHARGE]};
      if (wr4) cfg_q <= pwdata[15:13];
      if (wr && paddr == `ACSTC_OFF_SCAN_SELECT) mask_q <= pwdata[15:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_gnd; current_source_ground == sample_hold_discharge; endproperty
  a_gnd: assert property (p_gnd) else $error("ground and sink differ");
  property p_gnd_val; wr1 |-> ##2 current_source_ground == (dis_q[1] & dis_q[0]); endproperty
  a_gnd_val: assert property (p_gnd_val) else $error("ground not per enable and discharge bits");
  property p_nostart; sample_hold_discharge && $past(sample_hold_discharge) |-> !conv_start; endproperty
  a_nostart: assert property (p_nostart) else $error("start while discharging");
  property p_pulse; conv_start |=> !conv_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start too long");
  property p_ref_hi; wr4 |-> ##2 high_reference == {1'h0, !cfg_q[2] & cfg_q[0]}; endproperty
  a_ref_hi: assert property (p_ref_hi) else $error("high ref wrong");
  property p_ref_lo; wr4 |-> ##2 low_reference == {1'h0, !cfg_q[2] & cfg_q[1]}; endproperty
  a_ref_lo: assert property (p_ref_lo) else $error("low ref wrong");
  property p_ref_hold;
    !wr4 && !$past(wr4) && !$past(wr4, 2) |-> $stable(high_reference) && $stable(low_reference);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("ref moved");
  property p_lowref;
    $changed(conv_input_sel) |-> ##[0:1] conv_use_low_ref == (conv_input_sel >= NUM_INPUTS);
  endproperty
  a_lowref: assert property (p_lowref) else $error("absent input flag");
  property p_scan; $changed(conv_input_sel) |-> mask_q[conv_input_sel]; endproperty
  a_scan: assert property (p_scan) else $error("unmasked input");
  c_start: cover property ($rose(conv_start));
  c_lowref: cover property (conv_use_low_ref && $changed(conv_input_sel));
  c_gnd: cover property ($rose(current_source_ground));
endmodule // acstc_monitor
bind acstc_ctrl acstc_monitor #(.NUM_INPUTS(NUM_INPUTS)) u_mon (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
  .paddr, .pwdata, .conv_start, .current_source_ground, .sample_hold_discharge, .high_reference, .low_reference,
  .conv_input_sel, .conv_use_low_ref);
`default_nettype wire

// ==== verification/tb_top.sv ====
/* testbench for acstc_ctrl over apb with a converter model.
   assumes zero-wait apb slave and 40 ns pclk. */
`default_nettype none
`include "acstc_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'h0, presetn = 1'h0, ce = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        pready, pslverr, csg, shd, lowref, conv_start, conv_done, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0]  hw_edge = 2'h0, high_reference, low_reference;
  logic [3:0]  conv_input_sel;
  logic [15:0] edge_delay;
  logic [3:0]  seq [3] = '{4'hB, 4'h2, 4'h9};
  logic [31:0] wm [3] = '{32'hBF00, 32'hE77F, 32'hFFFF};
  int          bad_count = 0, cmp_count = 0;
  always #20 pclk = ~pclk;
  acstc_ctrl dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .hw_edge, .conv_done, .current_source_ground(csg), .conv_start, .sample_hold_discharge(shd),
    .high_reference, .low_reference, .conv_input_sel, .conv_use_low_ref(lowref), .edge_delay);
  acstc_conv_model u_conv (.pclk, .presetn, .conv_start, .conv_done);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    err = pslverr;
    if (n >= 16) begin
      bad_count++;
      report_and_stop;
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic pulse(input logic [1:0] e);
    @(posedge pclk);
    hw_edge <= e;
    @(posedge pclk);
    hw_edge <= 2'h0;
  endtask
  // mode 0 hardware edges in order, 1 reversed, 2 software edges
  task automatic trig(input logic [15:0] cc1, input logic [1:0] mode, input logic exp);
    logic got;
    got = 1'h0;
    xfer(1'h1, `ACSTC_OFF_CHARGE_CTRL1, {16'h0, cc1});
    xfer(1'h1, `ACSTC_OFF_CHARGE_STATUS, 32'hC);
    if (mode == 2'h2) begin
      xfer(1'h1, `ACSTC_OFF_CHARGE_STATUS, 32'h1);
      xfer(1'h1, `ACSTC_OFF_CHARGE_STATUS, 32'h2);
    end else begin
      pulse(mode[0] ? 2'h2 : 2'h1);
      repeat (3) @(posedge pclk);
      pulse(mode[0] ? 2'h1 : 2'h2);
    end
    repeat (12) begin
      @(negedge pclk);
      got |= conv_start;
    end
    chk(got, exp);
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    report_and_stop;
  end
  // register defaults, write masks, read-only buffer half bit, unmapped access
  task automatic t_regs;
    for (int k = 0; k < 3; k++) begin
      xfer(1'h0, 12'(k * 4), 32'h0);
      chk(rd, 32'h0);
      xfer(1'h1, 12'(k * 4), 32'hFFFFFFFF);
      xfer(1'h0, 12'(k * 4), 32'h0);
      chk(rd, wm[k]);
    end
    xfer(1'h0, 12'h010, 32'h0);
    chk(err, 1'h1);
    chk(rd, 32'h0);
  endtask
  // every reference code, 1xx included
  task automatic t_refs;
    logic [3:0] e;
    for (int c = 0; c < 8; c++) begin
      e = {1'h0, c[2:0] == 3'h1 || c[2:0] == 3'h3, 1'h0, c[2:0] == 3'h2 || c[2:0] == 3'h3};
      xfer(1'h1, `ACSTC_OFF_CONV_CTRL2, c << 13);
      repeat (2) @(posedge pclk);
      chk({high_reference, low_reference}, e);
    end
  endtask
  // a write while the clock enable is low must not land
  task automatic t_scan_ce;
    xfer(1'h1, `ACSTC_OFF_SCAN_SELECT, 32'h0A04);
    ce <= 1'h0;
    xfer(1'h1, `ACSTC_OFF_SCAN_SELECT, 32'h0);
    ce <= 1'h1;
    xfer(1'h0, `ACSTC_OFF_SCAN_SELECT, 32'h0);
    chk(rd, 32'h0A04);
    xfer(1'h1, `ACSTC_OFF_CONV_CTRL2, 32'h0400);
  endtask
  // edge source, ordering, enable, trigger and discharge gating
  task automatic t_edges;
    trig(16'h9D00, 2'h0, 1'h1);
    chk(edge_delay, 16'h0005);
    trig(16'h9C00, 2'h0, 1'h0);
    trig(16'h1D00, 2'h0, 1'h0);
    trig(16'h9D00, 2'h1, 1'h0);
    trig(16'h9500, 2'h0, 1'h0);
    trig(16'h9500, 2'h2, 1'h1);
    trig(16'h9F00, 2'h0, 1'h0);
    chk({csg, shd}, 2'h3);
    xfer(1'h1, `ACSTC_OFF_CHARGE_CTRL1, 32'h0200);
    repeat (2) @(posedge pclk);
    chk(csg, 1'h0);
    chk(shd, 1'h0);
  endtask
  // scan order over the mask, absent inputs, buffer half after sixteen results
  task automatic t_scan;
    for (int i = 0; i < 16; i++) begin
      trig(16'h9D00, 2'h0, 1'h1);
      chk(conv_input_sel, seq[i % 3]);
      chk(lowref, seq[i % 3] > 4'h8);
    end
    xfer(1'h0, `ACSTC_OFF_CONV_CTRL2, 32'h0);
    chk(rd[7], 1'h1);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_refs;
    t_scan_ce;
    t_edges;
    t_scan;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
